// file: rtl/flash_guard_pkg.sv
package flash_guard_pkg;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_NS            = 10;
   localparam int WRITE_STARTUP_DELAY_MS   = 15;
   localparam int WRITE_STARTUP_CYCLES     = (WRITE_STARTUP_DELAY_MS * 1000000) / CLK_PERIOD_NS;
   localparam int SELECT_AFTER_SUPPLY_US   = 10;
   localparam int BUSY_CYCLES_DEFAULT      = 1000;
   // -----------------------------------------------------------------
   // Commands
   // -----------------------------------------------------------------
   localparam logic [7:0] WRITE_PERMIT_CMD     = 8'h06;
   localparam logic [7:0] STATUS_WRITE_CMD     = 8'h01;
   localparam logic [7:0] STATUS_READ_CMD      = 8'h05;
   localparam logic [7:0] PAGE_PROGRAM_CMD     = 8'h02;
   localparam logic [7:0] BLOCK_WIPE_CMD       = 8'hD8;
   localparam logic [7:0] FULL_WIPE_CMD        = 8'hC7;
   localparam logic [7:0] WAKE_AND_ID_READ_CMD = 8'hAB;
   // -----------------------------------------------------------------
   // Status register layout and reset values
   // -----------------------------------------------------------------
   localparam int         STATUS_BUSY_BIT   = 0;
   localparam int         STATUS_PERMIT_BIT = 1;
   localparam logic [7:0] STATUS_RESET      = 8'h00;
   localparam logic [7:0] ARRAY_ERASED      = 8'hFF;
   localparam int         ID_DUMMY_BITS     = 32;
   typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_SHIFT_IN, ST_ID_OUT, ST_STATUS_OUT, ST_IGNORE} link_state_t;
endpackage : flash_guard_pkg

// file: rtl/sync2.sv
`timescale 1ns/10ps
`default_nettype none
module sync2 (
   // Clock and reset
   input  wire logic clk_sys_in,
   input  wire logic arst_n_in,
   // Data
   input  wire logic d_in,
   output logic      q_out
);
   logic stage1;
   logic next_stage1;
   logic next_q;
   always_comb begin
      next_stage1 = d_in;
      next_q      = stage1;
   end
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         stage1 <= 1'b1;
         q_out  <= 1'b1;
      end else begin
         stage1 <= next_stage1;
         q_out  <= next_q;
      end
   end
endmodule // sync2
`default_nettype wire

// file: rtl/flash_powerup_write_guard.sv
// Operation
// - After power-up: standby, deselected, write-permit latch cleared.
// - Block program, erase, status write while supply below inhibit threshold.
// - Allow writes only after 15 ms start-up delay above threshold.
// - Write-type commands execute only if release follows whole bytes.
// - Ignore array access during internal cycle; cycle completes.
// - Fixed 8-bit signature readable by wake-and-identify command.
// - Delivery state array reads all ones.
// - Status register starts at zero.
// - Identify: command, three dummy bytes, signature repeats on falling edges.
// - Writes need permit latch; latch clears when cycle completes.
`timescale 1ns/10ps
`default_nettype none
module flash_powerup_write_guard
   import flash_guard_pkg::*;
#(
   parameter int STARTUP_CYCLES = WRITE_STARTUP_CYCLES,
   parameter int BUSY_CYCLES    = BUSY_CYCLES_DEFAULT,
   parameter logic [7:0] SIGNATURE = 8'h5A  // Arbitrary value
)(
   // System
   input  wire logic clk_sys_in,
   input  wire logic arst_n_in,
   // Supply monitor
   input  wire logic supply_ok_in,
   // Serial link
   input  wire logic sclk_in,
   input  wire logic sel_n_in,
   input  wire logic sdi_in,
   output logic      sdo_out,
   output logic      sdo_oe_out,
   // Status
   output logic      write_allowed_out,
   output logic      busy_out,
   output logic      write_permit_latch_out,
   output logic [7:0] status_out,
   output logic      array_byte_out_valid_out
);
   logic sclk_s, sel_n_s, sdi_s, supply_low_s;
   sync2 u_sync_clk (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .d_in(sclk_in),      .q_out(sclk_s));
   sync2 u_sync_sel (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .d_in(sel_n_in),     .q_out(sel_n_s));
   sync2 u_sync_sdi (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .d_in(sdi_in),       .q_out(sdi_s));
   // Inverted so the synchroniser's reset level reads as low supply
   sync2 u_sync_sup (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .d_in(~supply_ok_in), .q_out(supply_low_s));

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   link_state_t state, next_state;
   logic        sclk_d, sel_d;
   logic [5:0]  bit_cnt, next_bit_cnt;
   logic [7:0]  shreg, next_shreg;
   logic [7:0]  cmd, next_cmd;
   logic [7:0]  out_sh, next_out_sh;
   logic        sdo, next_sdo;
   logic        sdo_oe, next_sdo_oe;
   logic [31:0] startup_cnt, next_startup_cnt;
   logic        allowed, next_allowed;
   logic [31:0] busy_cnt, next_busy_cnt;
   logic        busy, next_busy;
   logic        permit, next_permit;
   logic [7:0]  status, next_status;
   logic        array_valid, next_array_valid;
   logic        rise, fall, sel_edge, desel_edge;

   assign rise       = sclk_s & ~sclk_d;
   assign fall       = ~sclk_s & sclk_d;
   assign sel_edge   = ~sel_n_s & sel_d;
   assign desel_edge = sel_n_s & ~sel_d;

   always_comb begin
      next_state       = state;
      next_bit_cnt     = bit_cnt;
      next_shreg       = shreg;
      next_cmd         = cmd;
      next_out_sh      = out_sh;
      next_sdo         = sdo;
      next_sdo_oe      = ~sel_n_s & sdo_oe;
      next_startup_cnt = startup_cnt;
      next_allowed     = allowed;
      next_busy_cnt    = busy_cnt;
      next_busy        = busy;
      next_permit      = permit;
      next_status      = status;
      next_array_valid = 1'b0;
      if (supply_low_s) begin
         next_startup_cnt = '0;
         next_allowed     = 1'b0;
      end else if (!allowed) begin
         if (startup_cnt >= 32'(STARTUP_CYCLES - 1)) next_allowed = 1'b1;
         else next_startup_cnt = startup_cnt + 32'd1;
      end
      if (busy) begin
         if (busy_cnt >= 32'(BUSY_CYCLES - 1)) begin
            next_busy   = 1'b0;
            next_permit = 1'b0;
         end else next_busy_cnt = busy_cnt + 32'd1;
      end
      if (sel_edge) begin
         next_state   = busy ? ST_IGNORE : ST_CMD;
         next_bit_cnt = '0;
      end else if (!sel_n_s) begin
         if (rise) begin
            next_bit_cnt = bit_cnt + 6'd1;
            next_shreg   = {shreg[6:0], sdi_s};
            if (state == ST_CMD && bit_cnt == 6'd7) begin
               next_cmd = {shreg[6:0], sdi_s};
               if ({shreg[6:0], sdi_s} == STATUS_READ_CMD) begin
                  next_state  = ST_STATUS_OUT;
                  next_out_sh = status;
               end else next_state = ST_SHIFT_IN;
            end
            if (state == ST_SHIFT_IN && bit_cnt == 6'(ID_DUMMY_BITS - 1) && cmd == WAKE_AND_ID_READ_CMD) begin
               next_state  = ST_ID_OUT;
               next_out_sh = SIGNATURE;
            end
            if (state == ST_SHIFT_IN && cmd == 8'h03 && bit_cnt >= 6'd31) begin
               next_sdo    = ARRAY_ERASED[7];
               next_sdo_oe = 1'b1;
            end
            if (state == ST_SHIFT_IN && cmd == 8'h03 && bit_cnt >= 6'd32 && bit_cnt[2:0] == 3'd7)
               next_array_valid = 1'b1;
         end
         if (fall && (state == ST_ID_OUT || state == ST_STATUS_OUT)) begin
            next_sdo    = out_sh[7];
            next_sdo_oe = 1'b1;
            next_out_sh = {out_sh[6:0], out_sh[7]};
         end
      end else if (desel_edge) begin
         next_state = ST_IDLE;
         if (state == ST_SHIFT_IN && bit_cnt[2:0] == 3'd0 && !busy) begin
            if (cmd == WRITE_PERMIT_CMD && bit_cnt == 6'd8) next_permit = 1'b1;
            else if (allowed && permit &&
                     ((cmd == PAGE_PROGRAM_CMD && bit_cnt >= 6'd40) ||
                      (cmd == BLOCK_WIPE_CMD && bit_cnt == 6'd32) ||
                      (cmd == FULL_WIPE_CMD && bit_cnt == 6'd8) ||
                      (cmd == STATUS_WRITE_CMD && bit_cnt == 6'd16))) begin
               next_busy     = 1'b1;
               next_busy_cnt = '0;
               if (cmd == STATUS_WRITE_CMD) next_status = {shreg[7:2], 2'b00};
            end
         end
      end
      next_status[STATUS_BUSY_BIT]   = next_busy;
      next_status[STATUS_PERMIT_BIT] = next_permit;
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state       <= ST_IDLE;
         // Matches the synchroniser's reset level, no false edge
         sclk_d      <= 1'b1;
         sel_d       <= 1'b1;
         bit_cnt     <= '0;
         shreg       <= '0;
         cmd         <= '0;
         out_sh      <= '0;
         sdo         <= 1'b0;
         sdo_oe      <= 1'b0;
         startup_cnt <= '0;
         allowed     <= 1'b0;
         busy_cnt    <= '0;
         busy        <= 1'b0;
         permit      <= 1'b0;
         status      <= STATUS_RESET;
         array_valid <= 1'b0;
      end else begin
         state       <= next_state;
         sclk_d      <= sclk_s;
         sel_d       <= sel_n_s;
         bit_cnt     <= next_bit_cnt;
         shreg       <= next_shreg;
         cmd         <= next_cmd;
         out_sh      <= next_out_sh;
         sdo         <= next_sdo;
         sdo_oe      <= next_sdo_oe;
         startup_cnt <= next_startup_cnt;
         allowed     <= next_allowed;
         busy_cnt    <= next_busy_cnt;
         busy        <= next_busy;
         permit      <= next_permit;
         status      <= next_status;
         array_valid <= next_array_valid;
      end
   end

   assign sdo_out                  = sdo;
   assign sdo_oe_out               = sdo_oe;
   assign write_allowed_out        = allowed;
   assign busy_out                 = busy;
   assign write_permit_latch_out   = permit;
   assign status_out               = status;
   assign array_byte_out_valid_out = array_valid;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_supply_blocks: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      supply_low_s |=> !allowed) else $error("write allowed with low supply");
   a_busy_needs_allowed: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      $rose(busy) |-> $past(allowed) && $past(permit)) else $error("write without permit");
   a_whole_bytes: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      $rose(busy) |-> $past(bit_cnt[2:0]) == 3'd0) else $error("partial byte write");
   a_busy_ignore: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      busy && sel_edge |=> state == ST_IGNORE) else $error("access during cycle");
   a_permit_clear: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      $fell(busy) |-> !permit) else $error("latch not cleared");
   a_status_bits: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      status[STATUS_BUSY_BIT] == busy && status[STATUS_PERMIT_BIT] == permit) else $error("status mismatch");
   a_edge_count: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      !sel_n_s && !sel_edge && rise && state != ST_ID_OUT |=> bit_cnt == $past(bit_cnt) + 6'd1)
      else $error("edge count");
   a_no_drive_idle: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
      sel_n_s |=> !sdo_oe) else $error("drive while deselected");
endmodule // flash_powerup_write_guard
`default_nettype wire

// file: verification/host_spi_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_spi_model (
   // Link pins
   output logic        sclk_out,
   output logic        sel_n_out,
   output logic        sdi_out,
   input  wire logic   sdo_in
);
   logic [15:0] rx;
   initial begin
      sclk_out  = 1'b0;
      sel_n_out = 1'b1;
      sdi_out   = 1'b0;
      rx        = 16'h0000;
   end
   task automatic xfer(input logic [39:0] bits, input int nbits, input int nrd);
      sel_n_out = 1'b0;
      #40;
      for (int i = 0; i < nbits + nrd; i++) begin
         // Past the request, data line toggles so no stale level lingers
         sdi_out = (i < nbits) ? bits[39 - i] : ~sdi_out;
         #40 sclk_out = 1'b1;
         // Sample late in the high phase, output settled after sync delay
         #40 rx = {rx[14:0], sdo_in};
         sclk_out = 1'b0;
      end
      #40 sel_n_out = 1'b1;
      #60 sdi_out = ~sdi_out;
   endtask
endmodule // host_spi_model
`default_nettype wire

// file: verification/flash_powerup_write_guard_test.sv
`timescale 1ns/10ps
`default_nettype none
module flash_powerup_write_guard_test;
   import flash_guard_pkg::*;
   localparam logic [7:0] SIG  = 8'h5A; // Arbitrary value
   localparam int         BUSY = 400;
   typedef struct {logic [39:0] b; int n; logic pre; logic exp;} row_t;
   logic       clk_sys_in   = 1'b0;
   logic       arst_n_in    = 1'b0;
   logic       supply_ok_in = 1'b0;
   logic       sclk, sel_n, sdi, sdo, oe, wr_ok, busy, permit, oe_seen;
   logic       arr_v, arr_seen;
   logic [7:0] status;
   int         bad_count = 0;
   int         checked   = 0;
   row_t       rows[7];
   always #5 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in) if (oe) oe_seen <= 1'b1;
   always @(posedge clk_sys_in) if (arr_v) arr_seen <= 1'b1;
   host_spi_model host (.sclk_out(sclk), .sel_n_out(sel_n), .sdi_out(sdi), .sdo_in(sdo));
   flash_powerup_write_guard #(.STARTUP_CYCLES(100), .BUSY_CYCLES(BUSY), .SIGNATURE(SIG)) dut (
      .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .supply_ok_in(supply_ok_in),
      .sclk_in(sclk), .sel_n_in(sel_n), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(oe),
      .write_allowed_out(wr_ok), .busy_out(busy), .write_permit_latch_out(permit),
      .status_out(status), .array_byte_out_valid_out(arr_v));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cycles(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask
   task automatic reset_dut;
      arst_n_in = 1'b0;
      cycles(5);
      arst_n_in = 1'b1;
      cycles(3);
   endtask
   task automatic send(input logic [39:0] b, input int n, input logic pre);
      if (pre) host.xfer({WRITE_PERMIT_CMD, 32'h0000_0000}, 8, 0);
      host.xfer(b, n, 0);
      cycles(10);
   endtask
   // Bounded wait for the internal cycle to end
   task automatic wait_idle;
      int k;
      k = 0;
      while (busy !== 1'b0 && k < 2 * BUSY) begin
         cycles(1);
         k++;
      end
      if (k >= 2 * BUSY) begin
         bad_count++;
         conclude();
      end
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      rows = '{'{{FULL_WIPE_CMD, 32'h0000_0000}, 8, 1'b0, 1'b0},
               '{{FULL_WIPE_CMD, 32'h0000_0000}, 9, 1'b1, 1'b0},
               '{{FULL_WIPE_CMD, 32'h0000_0000}, 8, 1'b1, 1'b1},
               '{{BLOCK_WIPE_CMD, 32'h0000_0000}, 32, 1'b1, 1'b1},
               '{{BLOCK_WIPE_CMD, 32'h0000_0000}, 31, 1'b1, 1'b0},
               '{{STATUS_WRITE_CMD, 32'h0000_0000}, 16, 1'b1, 1'b1},
               '{{PAGE_PROGRAM_CMD, 32'h0000_0000}, 40, 1'b1, 1'b1}};
      oe_seen = 1'b0;
      reset_dut();
      send({FULL_WIPE_CMD, 32'h0000_0000}, 8, 1'b1);
      chk(busy, 1'b0);
      $display("test supply_low done");
      // Second reset mid-run must restore the power-up state
      reset_dut();
      chk(status, STATUS_RESET);
      chk({wr_ok, busy, permit, oe}, 4'h0);
      supply_ok_in = 1'b1;
      cycles(50);
      chk(wr_ok, 1'b0);
      cycles(60);
      chk(wr_ok, 1'b1);
      cycles(1000);
      $display("test startup done");
      foreach (rows[i]) begin
         send(rows[i].b, rows[i].n, rows[i].pre);
         chk(busy, rows[i].exp);
         if (rows[i].exp) begin
            chk(status[STATUS_BUSY_BIT], 1'b1);
            wait_idle();
            chk(permit, 1'b0);
         end
         $display("test row %0d done", i);
      end
      send({FULL_WIPE_CMD, 32'h0000_0000}, 8, 1'b1);
      oe_seen = 1'b0;
      host.xfer({WAKE_AND_ID_READ_CMD, 32'h0000_0000}, 32, 8);
      chk({oe_seen, busy}, 2'h1);
      wait_idle();
      chk(permit, 1'b0);
      $display("test busy_ignore done");
      host.xfer({WAKE_AND_ID_READ_CMD, 32'h0000_0000}, 32, 16);
      chk(host.rx, {SIG, SIG});
      cycles(10);
      chk(oe, 1'b0);
      $display("test signature done");
      arr_seen = 1'b0;
      host.xfer({8'h03, 32'h0000_0000}, 32, 8);
      chk(host.rx[7:0], ARRAY_ERASED);
      chk(arr_seen, 1'b1);
      $display("test array_read done");
      conclude();
   end
endmodule // flash_powerup_write_guard_test
`default_nettype wire
